//--- common/hbcel_pkg.sv
// Operation
// - Port-three enable 0 disables and hides bus0 dev3 fn0; 1 enables it.
// - Port-one enable 0 disables and hides bus0 dev1 fn0; 1 enables it.
// - Single-port variant treats port-three enable as reserved.
// - Enable bit 0 reads constant 1, read-only; host bridge always on.
// - ECC error stores 128-byte address in error address bits 31:7.
// - Logged address is the post-remap contiguous logical address.
// - After flag clear, log first single-bit or first multi-bit error.
// - Logged multi-bit error locks the address against later errors.
// - Bit 0 of error address records failing channel, 0 or 1.
// - Log fields are sticky; only power-good reset clears them.
// - Read ECC error loads syndrome of first bad quadword in chunk.
// - Multi-bit error overwrites a logged single-bit syndrome before clear.
// - Other errors after the first and before clear are not recorded.
// - Source code updates in the same event as the syndrome.
// - Source codes: 00h processor, 08h-09h link VC0, 0Ah-0Bh link VC1.
// - Primary port codes 10h,12h,14h-15h; secondary 20h,22h,24h-25h.
// - Bits 5:4 steer top segment: 00 link, 01 rd DRAM, 10 wr DRAM, 11 both.
// - Segment attributes apply to processor and PCI initiator accesses alike.
package hbcel_pkg;

	// Register byte offsets in configuration space
	localparam logic [7:0] OFF_FUNC_EN = 8'h54;
	localparam logic [7:0] OFF_ERR_ADDR = 8'h58;
	localparam logic [7:0] OFF_ERR_SYN = 8'h5c;
	localparam logic [7:0] OFF_ERR_SRC = 8'h5d;
	localparam logic [7:0] OFF_SEG_ATTR = 8'h90;

	// Field positions
	localparam int FE_HOST_BIT = 0;
	localparam int FE_P1_BIT = 1;
	localparam int FE_P3_BIT = 2;
	localparam int EA_CHAN_BIT = 0;
	localparam int EA_ADDR_LSB = 7;
	localparam int SEG_ATTR_LSB = 4;
	localparam int SRC_W = 6;
	localparam int SYN_W = 8;
	localparam int LINE_W = 25;

	// Reset values
	localparam logic FE_HOST_VAL = 1'b1;
	localparam logic FE_P1_RST = 1'b1;
	localparam logic FE_P3_RST = 1'b0;
	localparam logic [1:0] SEG_ATTR_RST = 2'h0;

	// Source code bases
	localparam logic [5:0] SRC_CPU = 6'h00;
	localparam logic [5:0] SRC_VC0 = 6'h08;
	localparam logic [5:0] SRC_VC1 = 6'h0a;
	localparam logic [5:0] SRC_PRI = 6'h10;
	localparam logic [5:0] SRC_SEC = 6'h20;
	localparam logic [5:0] SRC_PAIR_OFS = 6'h04;

	typedef enum logic [2:0] {
		REQ_CPU,
		REQ_HUB_VC0,
		REQ_HUB_VC1,
		REQ_PORT_PRI,
		REQ_PORT_SEC
	} hbcel_requester_type;

	typedef struct packed {
		logic req;
		logic we;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} hbcel_cfg_req_type;

	typedef struct packed {
		logic valid;
		logic multi;
		logic is_read;
		logic channel;
		logic [LINE_W-1:0] line;
		logic [SYN_W-1:0] syndrome;
		hbcel_requester_type requester;
		logic [1:0] sub;
	} hbcel_ecc_evt_type;

	typedef struct packed {
		logic [LINE_W-1:0] base;
		logic [LINE_W-1:0] limit;
		logic [LINE_W-1:0] target;
	} hbcel_remap_type;

	// Only legal codes can be produced; reserved ones never appear
	function automatic logic [5:0] source_code(input hbcel_requester_type r,
			input logic [1:0] sub);
		logic [5:0] port_ofs;
		port_ofs = sub[1] ? (SRC_PAIR_OFS | {5'h00, sub[0]}) : {4'h0, sub[0], 1'b0};
		unique case (r)
			REQ_CPU: source_code = SRC_CPU;
			REQ_HUB_VC0: source_code = SRC_VC0 | {5'h00, sub[0]};
			REQ_HUB_VC1: source_code = SRC_VC1 | {5'h00, sub[0]};
			REQ_PORT_PRI: source_code = SRC_PRI | port_ofs;
			default: source_code = SRC_SEC | port_ofs;
		endcase
	endfunction : source_code

endpackage : hbcel_pkg

//--- rtl/hbcel_remap.sv
`timescale 1ns/10ps
module hbcel_remap (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Window and raw event
	input wire hbcel_pkg::hbcel_remap_type win_i,
	input wire hbcel_pkg::hbcel_ecc_evt_type evt_i,
	// Translated event, one cycle later
	output hbcel_pkg::hbcel_ecc_evt_type evt_o
);
	logic in_win;
	logic [hbcel_pkg::LINE_W-1:0] moved;

	assign in_win = (evt_i.line >= win_i.base) && (evt_i.line <= win_i.limit);
	assign moved = win_i.target + (evt_i.line - win_i.base);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			evt_o <= '0;
		end else begin
			evt_o <= evt_i;
			if (in_win) begin
				evt_o.line <= moved;
			end
		end
	end
endmodule : hbcel_remap

//--- rtl/hbcel_ecc_log.sv
`timescale 1ns/10ps
module hbcel_ecc_log (
	// Clock and power-good reset only
	input wire logic clock_i,
	input wire logic pg_rst_n_i,
	// Events and flag clear
	input wire hbcel_pkg::hbcel_ecc_evt_type evt_i,
	input wire logic flag_clear_i,
	// Logged state
	output logic logged_o,
	output logic multi_o,
	output logic channel_o,
	output logic [hbcel_pkg::LINE_W-1:0] line_o,
	output logic [hbcel_pkg::SYN_W-1:0] syndrome_o,
	output logic [hbcel_pkg::SRC_W-1:0] source_o
);
	logic take;
	logic nxt_logged;
	logic nxt_multi;

	// Clear in the same cycle as an event: the event is kept
	assign take = evt_i.valid && (!logged_o || flag_clear_i ||
		(!multi_o && evt_i.multi));
	assign nxt_logged = (logged_o && !flag_clear_i) || take;
	assign nxt_multi = (multi_o && !flag_clear_i) || (take && evt_i.multi);

	// Sticky: only power-good reset reaches these
	always_ff @(posedge clock_i or negedge pg_rst_n_i) begin
		if (!pg_rst_n_i) begin
			logged_o <= 1'b0;
			multi_o <= 1'b0;
		end else begin
			logged_o <= nxt_logged;
			multi_o <= nxt_multi;
		end
	end

	always_ff @(posedge clock_i or negedge pg_rst_n_i) begin
		if (!pg_rst_n_i) begin
			line_o <= '0;
			channel_o <= 1'b0;
		end else if (take) begin
			line_o <= evt_i.line;
			channel_o <= evt_i.channel;
		end
	end

	always_ff @(posedge clock_i or negedge pg_rst_n_i) begin
		if (!pg_rst_n_i) begin
			syndrome_o <= '0;
			source_o <= '0;
		end else if (take && evt_i.is_read) begin
			syndrome_o <= evt_i.syndrome;
			source_o <= hbcel_pkg::source_code(evt_i.requester, evt_i.sub);
		end
	end
endmodule : hbcel_ecc_log

//--- rtl/hbcel_top.sv
`timescale 1ns/10ps
module hbcel_top #(
	parameter bit DUAL_PORT = 1'b1
) (
	// Clock and resets
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic pg_rst_n_i,
	// Configuration access
	input wire hbcel_pkg::hbcel_cfg_req_type cfg_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	// Memory controller side
	input wire hbcel_pkg::hbcel_ecc_evt_type ecc_evt_i,
	input wire hbcel_pkg::hbcel_remap_type remap_i,
	input wire logic flag_clear_i,
	output logic err_logged_o,
	// Function enables
	output logic port_one_enable_o,
	output logic port_three_enable_o,
	// Top segment steering, shared by all initiators
	output logic seg_read_dram_o,
	output logic seg_write_dram_o
);
	logic [1:0] rst_sync_ff;
	logic [1:0] pg_sync_ff;
	logic rst_n;
	logic pg_rst_n;
	logic p1_en_ff;
	logic p3_en_ff;
	logic [1:0] seg_attr_ff;
	hbcel_pkg::hbcel_ecc_evt_type evt_xl;
	logic log_logged;
	logic log_multi;
	logic log_chan;
	logic [hbcel_pkg::LINE_W-1:0] log_line;
	logic [hbcel_pkg::SYN_W-1:0] log_syn;
	logic [hbcel_pkg::SRC_W-1:0] log_src;
	logic wr_func;
	logic wr_seg;
	logic [31:0] nxt_rdata;

	function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
		hits = a[7:2] == off[7:2];
	endfunction : hits

	// Async assert, synchronous release
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	always_ff @(posedge clock_i or negedge pg_rst_n_i) begin
		if (!pg_rst_n_i) begin
			pg_sync_ff <= 2'h0;
		end else begin
			pg_sync_ff <= {pg_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];
	assign pg_rst_n = pg_sync_ff[1];

	assign wr_func = cfg_i.req && cfg_i.we && hits(cfg_i.addr, hbcel_pkg::OFF_FUNC_EN) &&
		cfg_i.be[0];
	assign wr_seg = cfg_i.req && cfg_i.we && hits(cfg_i.addr, hbcel_pkg::OFF_SEG_ATTR) &&
		cfg_i.be[0];

	// Function enables
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			p1_en_ff <= hbcel_pkg::FE_P1_RST;
			p3_en_ff <= hbcel_pkg::FE_P3_RST & DUAL_PORT;
		end else if (wr_func) begin
			p1_en_ff <= cfg_i.wdata[hbcel_pkg::FE_P1_BIT];
			p3_en_ff <= cfg_i.wdata[hbcel_pkg::FE_P3_BIT] & DUAL_PORT;
		end
	end

	// Segment attribute; only bits 5:4 are stored
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			seg_attr_ff <= hbcel_pkg::SEG_ATTR_RST;
		end else if (wr_seg) begin
			seg_attr_ff <= cfg_i.wdata[hbcel_pkg::SEG_ATTR_LSB +: 2];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			port_one_enable_o <= hbcel_pkg::FE_P1_RST;
			port_three_enable_o <= hbcel_pkg::FE_P3_RST & DUAL_PORT;
			seg_read_dram_o <= 1'b0;
			seg_write_dram_o <= 1'b0;
		end else begin
			port_one_enable_o <= p1_en_ff;
			port_three_enable_o <= p3_en_ff;
			// Low bit is read enable, high bit write enable
			seg_read_dram_o <= seg_attr_ff[0];
			seg_write_dram_o <= seg_attr_ff[1];
		end
	end

	hbcel_remap u_remap (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.win_i(remap_i),
		.evt_i(ecc_evt_i),
		.evt_o(evt_xl)
	);

	hbcel_ecc_log u_log (
		.clock_i(clock_i),
		.pg_rst_n_i(pg_rst_n),
		.evt_i(evt_xl),
		.flag_clear_i(flag_clear_i),
		.logged_o(log_logged),
		.multi_o(log_multi),
		.channel_o(log_chan),
		.line_o(log_line),
		.syndrome_o(log_syn),
		.source_o(log_src)
	);

	// Read mux; unmapped and reserved bits return zero
	always_comb begin
		nxt_rdata = 32'h0;
		if (hits(cfg_i.addr, hbcel_pkg::OFF_FUNC_EN)) begin
			nxt_rdata[hbcel_pkg::FE_HOST_BIT] = hbcel_pkg::FE_HOST_VAL;
			nxt_rdata[hbcel_pkg::FE_P1_BIT] = p1_en_ff;
			nxt_rdata[hbcel_pkg::FE_P3_BIT] = p3_en_ff;
		end else if (hits(cfg_i.addr, hbcel_pkg::OFF_ERR_ADDR)) begin
			nxt_rdata[hbcel_pkg::EA_ADDR_LSB +: hbcel_pkg::LINE_W] = log_line;
			nxt_rdata[hbcel_pkg::EA_CHAN_BIT] = log_chan;
		end else if (hits(cfg_i.addr, hbcel_pkg::OFF_ERR_SYN)) begin
			nxt_rdata[8*hbcel_pkg::OFF_ERR_SYN[1:0] +: hbcel_pkg::SYN_W] = log_syn;
			nxt_rdata[8*hbcel_pkg::OFF_ERR_SRC[1:0] +: hbcel_pkg::SRC_W] = log_src;
		end else if (hits(cfg_i.addr, hbcel_pkg::OFF_SEG_ATTR)) begin
			nxt_rdata[hbcel_pkg::SEG_ATTR_LSB +: 2] = seg_attr_ff;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ack_o <= 1'b0;
			cfg_rdata_o <= 32'h0;
			err_logged_o <= 1'b0;
		end else begin
			cfg_ack_o <= cfg_i.req;
			cfg_rdata_o <= (cfg_i.req && !cfg_i.we) ? nxt_rdata : 32'h0;
			err_logged_o <= log_logged;
		end
	end

	// Multi lock state is visible through the log module only
	logic unused_multi;
	assign unused_multi = log_multi;
endmodule : hbcel_top

//--- test/hbcel_top_assertions.sv
`timescale 1ns/10ps
module hbcel_chk #(
	parameter bit DUAL_PORT = 1'b1
) (
	// Watched top ports
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic pg_rst_n_i,
	input wire hbcel_pkg::hbcel_cfg_req_type cfg_i,
	input wire logic cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire hbcel_pkg::hbcel_ecc_evt_type ecc_evt_i,
	input wire logic flag_clear_i,
	input wire logic err_logged_o,
	input wire logic port_one_enable_o,
	input wire logic port_three_enable_o,
	input wire logic seg_read_dram_o,
	input wire logic seg_write_dram_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i || !pg_rst_n_i);
	sequence s_rd(a);
		cfg_i.req && !cfg_i.we && cfg_i.addr[7:2] == a;
	endsequence
	sequence s_wr(a);
		cfg_i.req && cfg_i.we && cfg_i.be[0] && cfg_i.addr[7:2] == a;
	endsequence
	property p_host;
		s_rd(6'h15) |=> cfg_ack_o && cfg_rdata_o[0];
	endproperty
	a_host: assert property (p_host) else $error("host bit not read as one");
	property p_fe_rsvd;
		s_rd(6'h15) |=> cfg_rdata_o[31:3] == 29'h0;
	endproperty
	a_fe_rsvd: assert property (p_fe_rsvd) else $error("enable spare bits set");
	property p_seg_rsvd;
		s_rd(6'h24) |=> cfg_rdata_o[31:6] == 26'h0 && cfg_rdata_o[3:0] == 4'h0;
	endproperty
	a_seg_rsvd: assert property (p_seg_rsvd) else $error("segment spare bits set");
	property p_idle;
		!cfg_i.req |=> !cfg_ack_o && cfg_rdata_o == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_seg;
		s_wr(6'h24) |=> ##1 {seg_write_dram_o, seg_read_dram_o} == $past(cfg_i.wdata[5:4], 2);
	endproperty
	a_seg: assert property (p_seg) else $error("segment steering wrong");
	property p_p1;
		s_wr(6'h15) |=> ##1 port_one_enable_o == $past(cfg_i.wdata[1], 2);
	endproperty
	a_p1: assert property (p_p1) else $error("port one enable wrong");
	property p_p3;
		s_wr(6'h15) |=> ##1 port_three_enable_o == (DUAL_PORT && $past(cfg_i.wdata[2], 2));
	endproperty
	a_p3: assert property (p_p3) else $error("port three enable wrong");
	property p_log;
		ecc_evt_i.valid |-> ##[2:3] err_logged_o;
	endproperty
	a_log: assert property (p_log) else $error("error not logged");
	property p_hold;
		err_logged_o && !flag_clear_i && !$past(flag_clear_i) |=> err_logged_o;
	endproperty
	a_hold: assert property (p_hold) else $error("log lost without clear");
endmodule : hbcel_chk
bind hbcel_top hbcel_chk #(.DUAL_PORT(DUAL_PORT)) u_chk (.clock_i(clock_i),
	.rst_n_i(rst_n_i), .pg_rst_n_i(pg_rst_n_i), .cfg_i(cfg_i), .cfg_ack_o(cfg_ack_o),
	.cfg_rdata_o(cfg_rdata_o), .ecc_evt_i(ecc_evt_i), .flag_clear_i(flag_clear_i),
	.err_logged_o(err_logged_o), .port_one_enable_o(port_one_enable_o),
	.port_three_enable_o(port_three_enable_o), .seg_read_dram_o(seg_read_dram_o),
	.seg_write_dram_o(seg_write_dram_o));

//--- test/hbcel_top_tb.sv
`timescale 1ns/10ps
module hbcel_top_tb;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic pg_rst_n_i = 1'b0;
	logic flag_clear_i = 1'b0;
	hbcel_pkg::hbcel_cfg_req_type cfg_i = '0;
	hbcel_pkg::hbcel_ecc_evt_type ecc_evt_i = '0;
	hbcel_pkg::hbcel_remap_type remap_i = '{25'h100, 25'h1ff, 25'h800};
	logic cfg_ack_o, err_logged_o, p1_o, p3_o, srd_o, swr_o;
	logic [31:0] cfg_rdata_o, rd;
	logic p3_s;
	logic [31:0] rdata_s, rd_s;
	int fails = 0;
	int samples_checked = 0;
	// 3f marks combinations with no legal code
	logic [5:0] codes [5][4] = '{'{6'h00, 6'h3f, 6'h3f, 6'h3f}, '{6'h08, 6'h09, 6'h3f, 6'h3f},
		'{6'h0a, 6'h0b, 6'h3f, 6'h3f}, '{6'h10, 6'h12, 6'h14, 6'h15}, '{6'h20, 6'h22, 6'h24, 6'h25}};
	hbcel_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .pg_rst_n_i(pg_rst_n_i), .cfg_i(cfg_i),
		.cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .ecc_evt_i(ecc_evt_i),
		.remap_i(remap_i), .flag_clear_i(flag_clear_i), .err_logged_o(err_logged_o),
		.port_one_enable_o(p1_o), .port_three_enable_o(p3_o), .seg_read_dram_o(srd_o),
		.seg_write_dram_o(swr_o));
	// Single-port variant shares every input
	hbcel_top #(.DUAL_PORT(1'b0)) uut_single (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.pg_rst_n_i(pg_rst_n_i), .cfg_i(cfg_i), .cfg_ack_o(), .cfg_rdata_o(rdata_s),
		.ecc_evt_i(ecc_evt_i), .remap_i(remap_i), .flag_clear_i(flag_clear_i),
		.err_logged_o(), .port_one_enable_o(), .port_three_enable_o(p3_s),
		.seg_read_dram_o(), .seg_write_dram_o());
	initial forever #20 clock_i = ~clock_i;
	task automatic chk(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
		cfg_i = '{1'b1, we, a, 4'hf, d};
		cyc(1);
		// Ack and data stand for one cycle only
		chk("ack", {31'h0, cfg_ack_o}, 32'h1);
		rd = cfg_rdata_o;
		rd_s = rdata_s;
		cfg_i.req = 1'b0;
		cyc(1);
	endtask : acc
	task automatic ev(input logic m, ch, input logic [24:0] ln, input logic [7:0] sy,
			input hbcel_pkg::hbcel_requester_type r, input logic [1:0] s);
		ecc_evt_i = '{1'b1, m, 1'b1, ch, ln, sy, r, s};
		cyc(1);
		ecc_evt_i.valid = 1'b0;
		cyc(2);
	endtask : ev
	task automatic lg(input logic [31:0] a, s);
		acc(1'b0, 8'h58, 32'h0);
		chk("err_addr", rd, a);
		acc(1'b0, 8'h5c, 32'h0);
		chk("err_syn_src", rd, s);
	endtask : lg
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	initial begin
		cyc(12);
		rst_n_i = 1'b1;
		pg_rst_n_i = 1'b1;
		cyc(4);
		acc(1'b0, 8'h54, 32'h0);
		chk("func_en", rd, 32'h3);
		chk("func_en_single", rd_s, 32'h3);
		acc(1'b0, 8'h90, 32'h0);
		chk("seg_attr", rd, 32'h0);
		acc(1'b0, 8'h10, 32'h0);
		chk("unmapped", rd, 32'h0);
		acc(1'b1, 8'h58, 32'hffffffff);
		lg(32'h0, 32'h0);
		$display("test reset values done");
		acc(1'b1, 8'h54, 32'h0);
		cyc(1);
		chk("ports", {30'h0, p3_o, p1_o}, 32'h0);
		acc(1'b0, 8'h54, 32'h0);
		chk("func_en", rd, 32'h1);
		acc(1'b1, 8'h54, 32'hffffffff);
		cyc(1);
		chk("ports", {30'h0, p3_o, p1_o}, 32'h3);
		chk("p3_single", {31'h0, p3_s}, 32'h0);
		acc(1'b0, 8'h54, 32'h0);
		chk("func_en", rd, 32'h7);
		chk("func_en_single", rd_s, 32'h3);
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, 8'h90, {24'h0, 2'h3, i[1:0], 4'hf});
			cyc(1);
			chk("seg_pins", {30'h0, swr_o, srd_o}, i);
			acc(1'b0, 8'h90, 32'h0);
			chk("seg_attr", rd, i << 4);
		end
		$display("test registers done");
		// Window hit: line 123 lands at 823
		ev(1'b0, 1'b1, 25'h123, 8'h5a, hbcel_pkg::REQ_CPU, 2'h0);
		lg({25'h823, 7'h1}, 32'h5a);
		ev(1'b0, 1'b0, 25'h40, 8'h11, hbcel_pkg::REQ_HUB_VC0, 2'h1);
		lg({25'h823, 7'h1}, 32'h5a);
		ev(1'b1, 1'b0, 25'h40, 8'hc3, hbcel_pkg::REQ_PORT_PRI, 2'h2);
		lg({25'h40, 7'h0}, 32'h14c3);
		ev(1'b1, 1'b1, 25'h77, 8'h99, hbcel_pkg::REQ_PORT_SEC, 2'h3);
		lg({25'h40, 7'h0}, 32'h14c3);
		rst_n_i = 1'b0;
		cyc(2);
		rst_n_i = 1'b1;
		cyc(4);
		lg({25'h40, 7'h0}, 32'h14c3);
		chk("logged", {31'h0, err_logged_o}, 32'h1);
		$display("test error log done");
		for (int r = 0; r < 5; r++) begin
			for (int s = 0; s < 4; s++) begin
				if (codes[r][s] != 6'h3f) begin
					flag_clear_i = 1'b1;
					cyc(1);
					flag_clear_i = 1'b0;
					cyc(2);
					ev(1'b0, 1'b0, 25'h3, 8'h3c, hbcel_pkg::hbcel_requester_type'(r), s[1:0]);
					acc(1'b0, 8'h5c, 32'h0);
					chk("err_src", rd, {18'h0, codes[r][s], 8'h3c});
				end
			end
		end
		$display("test source codes done");
		pg_rst_n_i = 1'b0;
		cyc(2);
		pg_rst_n_i = 1'b1;
		cyc(4);
		lg(32'h0, 32'h0);
		chk("logged_pg", {31'h0, err_logged_o}, 32'h0);
		$display("test power good done");
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		conclude();
	end
endmodule : hbcel_top_tb
